// file: rtl/sbf_exec.sv
`timescale 1ns/1ps
`include "sbf_defines.svh"

module sbf_exec #(
	parameter int WREG_DEPTH = 32,
	parameter int IO_DEPTH   = 32
) (
	input  wire logic         pclk,         // Core clock, 100 MHz
	input  wire logic         presetn,      // Async reset, low active
	input  wire logic         psel,         // APB select
	input  wire logic         penable,      // APB access phase
	input  wire logic         pwrite,       // APB direction
	input  wire logic [11:0]  paddr,        // APB byte address
	input  wire logic [31:0]  pwdata,       // APB write data
	output logic      [31:0]  prdata,       // APB read data
	output logic              pready,       // APB ready
	output logic              pslverr,      // APB error, unmapped address
	output sbf_pkg::sbf_byte_t status_reg,  // Current status register
	output logic              irq_enable,   // Global interrupt enable flag
	output logic              sleep_req,    // One-cycle sleep request
	output logic              wdt_restart   // One-cycle watchdog restart
);
	import sbf_pkg::*;

	// Shift flag update: Z, C, N and V = N xor C
	function automatic sbf_byte_t shift_flags(sbf_byte_t s, sbf_byte_t r, logic c);
		sbf_byte_t o;
		o = s;
		o[`SBF_FLAG_Z] = (r == 8'h00);
		o[`SBF_FLAG_C] = c;
		o[`SBF_FLAG_N] = r[7];
		o[`SBF_FLAG_V] = r[7] ^ c;
		return o;
	endfunction

	// Flag position for the dedicated set/clear opcodes
	function automatic logic [2:0] flag_pos(sbf_op_e o);
		case (o)
			OP_SET_CARRY, OP_CLEAR_CARRY:               flag_pos = `SBF_FLAG_C;
			OP_SET_NEGATIVE, OP_CLEAR_NEGATIVE:         flag_pos = `SBF_FLAG_N;
			OP_SET_ZERO, OP_CLEAR_ZERO:                 flag_pos = `SBF_FLAG_Z;
			OP_IRQ_GLOBAL_ON, OP_IRQ_GLOBAL_OFF:        flag_pos = `SBF_FLAG_I;
			OP_SET_SIGNED_FLAG, OP_CLEAR_SIGNED_FLAG:   flag_pos = `SBF_FLAG_S;
			OP_SET_OVERFLOW, OP_CLEAR_OVERFLOW:         flag_pos = `SBF_FLAG_V;
			OP_TRANSFER_FLAG_ON, OP_TRANSFER_FLAG_OFF:  flag_pos = `SBF_FLAG_T;
			OP_SET_HALF_CARRY, OP_CLEAR_HALF_CARRY:     flag_pos = `SBF_FLAG_H;
			default:                                    flag_pos = `SBF_FLAG_C;
		endcase
	endfunction

	// Value forced by a dedicated set/clear opcode
	function automatic logic flag_val(sbf_op_e o);
		case (o)
			OP_SET_CARRY, OP_SET_NEGATIVE, OP_SET_ZERO, OP_IRQ_GLOBAL_ON,
			OP_SET_SIGNED_FLAG, OP_SET_OVERFLOW, OP_TRANSFER_FLAG_ON,
			OP_SET_HALF_CARRY:
				flag_val = 1'b1;
			default:
				flag_val = 1'b0;
		endcase
	endfunction

	// State and control registers
	sbf_state_e                   state_r;     // Engine state
	sbf_state_e                   state_nxt;   // Next engine state
	logic [`SBF_CMD_WIDTH-1:0]    cmd_r;       // Latched command word
	sbf_byte_t                    status_register_r;      // Status register
	logic                         sleep_r;     // Sleep pulse register
	logic                         wdt_r;       // Watchdog pulse register
	logic                         rd_wait_r;   // Memory read wait state

	// Command fields
	wire sbf_op_e    op      = sbf_op_e'(cmd_r[`SBF_CMD_OP_MSB:`SBF_CMD_OP_LSB]);
	wire logic [4:0] cmd_rd  = cmd_r[`SBF_CMD_RD_MSB:`SBF_CMD_RD_LSB];
	wire logic [2:0] cmd_bit = cmd_r[`SBF_CMD_BIT_MSB:`SBF_CMD_BIT_LSB];
	wire logic [4:0] cmd_io  = cmd_r[`SBF_CMD_IO_MSB:`SBF_CMD_IO_LSB];
	wire sbf_op_e    new_op  = sbf_op_e'(pwdata[`SBF_CMD_OP_MSB:`SBF_CMD_OP_LSB]);

	// APB decode
	wire logic apb_acc  = psel & penable;
	wire logic sel_cmd  = (paddr == `SBF_ADDR_CMD);
	wire logic sel_stat = (paddr == `SBF_ADDR_STAT);
	wire logic in_array = (paddr[7] == 1'b0) & (paddr[1:0] == 2'b00);
	wire logic sel_wreg = (paddr[11:8] == `SBF_WIN_WREG) & in_array;
	wire logic sel_io   = (paddr[11:8] == `SBF_WIN_IO) & in_array;
	wire logic mem_sel  = sel_wreg | sel_io;
	wire logic mapped   = sel_cmd | sel_stat | mem_sel;
	wire logic idle     = (state_r == ST_IDLE);
	wire logic [4:0] apb_idx = paddr[6:2];

	// Control reads answer at once; array reads and mapped writes wait for idle
	assign pready  = apb_acc & (~mapped | (~pwrite & ~mem_sel) |
		(idle & (pwrite | rd_wait_r)));
	assign pslverr = apb_acc & ~mapped;

	// Write strobes, valid only at the completing edge
	wire logic wr_fire  = apb_acc & pwrite & pready & mapped;
	wire logic start    = wr_fire & sel_cmd;
	wire logic stat_wr  = wr_fire & sel_stat;
	wire logic wreg_apb = wr_fire & sel_wreg;
	wire logic io_apb   = wr_fire & sel_io;

	// Operand-bearing opcodes need one read cycle before execute
	wire logic needs_reg = (new_op >= OP_LOGICAL_SHIFT_LEFT) & (new_op <= OP_NIBBLE_SWAP) |
		(new_op == OP_TRANSFER_FLAG_STORE) | (new_op == OP_TRANSFER_FLAG_LOAD);
	wire logic needs_io  = (new_op == OP_IO_BIT_CLEAR);
	wire logic exec      = (state_r == ST_EXEC);

	// Memory read data and engine results
	sbf_byte_t wreg_q;     // Working register read data
	sbf_byte_t io_q;       // I/O register read data
	sbf_byte_t res;        // Execute result
	sbf_byte_t status_register_nxt;   // Execute status result
	logic      res_wreg;   // Result goes to working register
	logic      res_io;     // Result goes to I/O register

	// Read ports follow the bus while idle, the command while busy
	wire logic [4:0] wreg_ra = idle ? apb_idx : cmd_rd;
	wire logic [4:0] io_ra   = idle ? apb_idx : cmd_io;
	wire logic       wreg_we = (exec & res_wreg) | wreg_apb;
	wire logic       io_we   = (state_r == ST_IO_WB) | io_apb;
	wire logic [4:0] wreg_wa = idle ? apb_idx : cmd_rd;
	wire logic [4:0] io_wa   = idle ? apb_idx : cmd_io;
	wire sbf_byte_t  wreg_wd = idle ? pwdata[7:0] : res;
	wire sbf_byte_t  io_wd   = idle ? pwdata[7:0] : io_q & ~(8'h01 << cmd_bit);

	// Working register array
	sbf_regfile #(
		.WIDTH (8),
		.DEPTH (WREG_DEPTH),
		.AW    (5)
	) u_wreg (
		.clk   (pclk),
		.rst_n (presetn),
		.we    (wreg_we),
		.waddr (wreg_wa),
		.wdata (wreg_wd),
		.raddr (wreg_ra),
		.rdata (wreg_q)
	);

	// I/O register array
	sbf_regfile #(
		.WIDTH (8),
		.DEPTH (IO_DEPTH),
		.AW    (5)
	) u_io (
		.clk   (pclk),
		.rst_n (presetn),
		.we    (io_we),
		.waddr (io_wa),
		.wdata (io_wd),
		.raddr (io_ra),
		.rdata (io_q)
	);

	// Execute datapath; status and result only used in the execute cycle
	always_comb
	begin
		res      = wreg_q;
		status_register_nxt = status_register_r;
		res_wreg = 1'b0;
		res_io   = 1'b0;
		case (op)
			OP_LOGICAL_SHIFT_LEFT:
			begin
				res      = {wreg_q[6:0], 1'b0};
				status_register_nxt = shift_flags(status_register_r, res, wreg_q[7]);
				res_wreg = 1'b1;
			end
			OP_LOGICAL_SHIFT_RIGHT:
			begin
				res      = {1'b0, wreg_q[7:1]};
				status_register_nxt = shift_flags(status_register_r, res, wreg_q[0]);
				res_wreg = 1'b1;
			end
			OP_ROTATE_LEFT_CARRY:
			begin
				res      = {wreg_q[6:0], status_register_r[`SBF_FLAG_C]};
				status_register_nxt = shift_flags(status_register_r, res, wreg_q[7]);
				res_wreg = 1'b1;
			end
			OP_ROTATE_RIGHT_CARRY:
			begin
				res      = {status_register_r[`SBF_FLAG_C], wreg_q[7:1]};
				status_register_nxt = shift_flags(status_register_r, res, wreg_q[0]);
				res_wreg = 1'b1;
			end
			OP_ARITH_SHIFT_RIGHT:
			begin
				res      = {wreg_q[7], wreg_q[7:1]};
				status_register_nxt = shift_flags(status_register_r, res, wreg_q[0]);
				res_wreg = 1'b1;
			end
			OP_NIBBLE_SWAP:
			begin
				res      = {wreg_q[3:0], wreg_q[7:4]};
				res_wreg = 1'b1;
			end
			OP_TRANSFER_FLAG_STORE:
				status_register_nxt[`SBF_FLAG_T] = wreg_q[cmd_bit];
			OP_TRANSFER_FLAG_LOAD:
			begin
				res[cmd_bit] = status_register_r[`SBF_FLAG_T];
				res_wreg     = 1'b1;
			end
			OP_IO_BIT_CLEAR:
				res_io = 1'b1;
			OP_STATUS_BIT_SET:
				status_register_nxt[cmd_bit] = 1'b1;
			OP_STATUS_BIT_CLEAR:
				status_register_nxt[cmd_bit] = 1'b0;
			OP_SET_SIGNED_FLAG, OP_CLEAR_SIGNED_FLAG,
			OP_SET_OVERFLOW, OP_CLEAR_OVERFLOW,
			OP_SET_HALF_CARRY, OP_CLEAR_HALF_CARRY,
			OP_SET_CARRY, OP_CLEAR_CARRY, OP_SET_NEGATIVE, OP_CLEAR_NEGATIVE,
			OP_SET_ZERO, OP_CLEAR_ZERO, OP_IRQ_GLOBAL_ON, OP_IRQ_GLOBAL_OFF,
			OP_TRANSFER_FLAG_ON, OP_TRANSFER_FLAG_OFF:
				status_register_nxt[flag_pos(op)] = flag_val(op);
			default:
				res = wreg_q;  // Nop, sleep, restart and unused codes change nothing
		endcase
	end

	// Sequencing: fetch for operands, one execute cycle, extra write-back for I/O
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
				if (start)
					state_nxt = (needs_reg | needs_io) ? ST_FETCH : ST_EXEC;
			ST_FETCH:
				state_nxt = ST_EXEC;
			ST_EXEC:
				state_nxt = res_io ? ST_IO_WB : ST_IDLE;
			ST_IO_WB:
				state_nxt = ST_IDLE;
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// Engine state and command latch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= ST_IDLE;
			cmd_r   <= `SBF_CMD_RST;
		end
		else
		begin
			state_r <= state_nxt;
			if (start)
				cmd_r <= pwdata[`SBF_CMD_WIDTH-1:0];
		end
	end

	// Status register: execute wins; bus load only happens while idle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_register_r <= `SBF_STATUS_REGISTER_RST;
		else if (exec)
			status_register_r <= status_register_nxt;  // flags kept where untouched
		else if (stat_wr)
			status_register_r <= pwdata[7:0];
	end

	// One-cycle pulses toward power management and watchdog
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sleep_r <= 1'b0;
			wdt_r   <= 1'b0;
		end
		else
		begin
			sleep_r <= exec & (op == OP_SLEEP);
			wdt_r   <= exec & (op == OP_WATCHDOG_RESTART);
		end
	end

	// Array reads need one wait cycle for the registered read port
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_wait_r <= 1'b0;
		else
			rd_wait_r <= apb_acc & ~pwrite & mem_sel & idle & ~rd_wait_r;
	end

	// Read data mux over registered sources; zeros above each field
	assign prdata = !apb_acc ? 32'h0000_0000 :
		sel_cmd  ? {14'h0000, cmd_r} :
		sel_stat ? {23'h00_0000, ~idle, status_register_r} :
		sel_wreg ? {24'h00_0000, wreg_q} :
		sel_io   ? {24'h00_0000, io_q} : 32'h0000_0000;

	assign status_reg  = status_register_r;
	assign irq_enable  = status_register_r[`SBF_FLAG_I];
	assign sleep_req   = sleep_r;
	assign wdt_restart = wdt_r;

endmodule

// file: rtl/sbf_defines.svh
`ifndef SBF_DEFINES_SVH
`define SBF_DEFINES_SVH

// APB byte addresses of the control words
`define SBF_ADDR_CMD      12'h000
`define SBF_ADDR_STAT     12'h004
// Window selects in paddr[11:8] for the two storage arrays
`define SBF_WIN_WREG      4'h1
`define SBF_WIN_IO        4'h2

// Command word layout
`define SBF_CMD_OP_LSB    0
`define SBF_CMD_OP_MSB    4
`define SBF_CMD_RD_LSB    5
`define SBF_CMD_RD_MSB    9
`define SBF_CMD_BIT_LSB   10
`define SBF_CMD_BIT_MSB   12
`define SBF_CMD_IO_LSB    13
`define SBF_CMD_IO_MSB    17
`define SBF_CMD_WIDTH     18

// Status word layout
`define SBF_STAT_BUSY_BIT 8

// Status register flag positions
`define SBF_FLAG_C        3'd0
`define SBF_FLAG_Z        3'd1
`define SBF_FLAG_N        3'd2
`define SBF_FLAG_V        3'd3
`define SBF_FLAG_S        3'd4
`define SBF_FLAG_H        3'd5
`define SBF_FLAG_T        3'd6
`define SBF_FLAG_I        3'd7

// Reset values
`define SBF_STATUS_REGISTER_RST      8'h00
`define SBF_CMD_RST       18'h00000
`define SBF_MEM_RD_RST    8'h00

// Execute-stage cycle counts
`define SBF_CYC_SINGLE    1
`define SBF_CYC_IO_CLEAR  2

`endif

// file: rtl/sbf_pkg.sv
package sbf_pkg;

	// Operation codes, numbered in declaration order from zero
	typedef enum logic [4:0]
	{
		OP_NO_OPERATION,
		OP_IO_BIT_CLEAR,
		OP_LOGICAL_SHIFT_LEFT,
		OP_LOGICAL_SHIFT_RIGHT,
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT_CARRY,
		OP_ARITH_SHIFT_RIGHT,
		OP_NIBBLE_SWAP,
		OP_STATUS_BIT_SET,
		OP_STATUS_BIT_CLEAR,
		OP_TRANSFER_FLAG_STORE,
		OP_TRANSFER_FLAG_LOAD,
		OP_SET_CARRY,
		OP_CLEAR_CARRY,
		OP_SET_NEGATIVE,
		OP_CLEAR_NEGATIVE,
		OP_SET_ZERO,
		OP_CLEAR_ZERO,
		OP_IRQ_GLOBAL_ON,
		OP_IRQ_GLOBAL_OFF,
		OP_SET_SIGNED_FLAG,
		OP_CLEAR_SIGNED_FLAG,
		OP_SET_OVERFLOW,
		OP_CLEAR_OVERFLOW,
		OP_TRANSFER_FLAG_ON,
		OP_TRANSFER_FLAG_OFF,
		OP_SET_HALF_CARRY,
		OP_CLEAR_HALF_CARRY,
		OP_SLEEP,
		OP_WATCHDOG_RESTART
	} sbf_op_e;

	// Engine sequencing states
	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_FETCH,
		ST_EXEC,
		ST_IO_WB
	} sbf_state_e;

	typedef logic [7:0] sbf_byte_t;

endpackage

// file: rtl/sbf_regfile.sv
`timescale 1ns/1ps
`include "sbf_defines.svh"

// Small synchronous memory, registered read port
module sbf_regfile #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	input  wire logic             clk,    // Core clock
	input  wire logic             rst_n,  // Async reset, low active
	input  wire logic             we,     // Write strobe
	input  wire logic [AW-1:0]    waddr,  // Write index
	input  wire logic [WIDTH-1:0] wdata,  // Write data
	input  wire logic [AW-1:0]    raddr,  // Read index
	output logic      [WIDTH-1:0] rdata   // Read data, one cycle late
);

	logic [WIDTH-1:0] mem_r [DEPTH];  // Storage, no reset on purpose
	logic [WIDTH-1:0] rdata_r;        // Read register

	// Array write; left without reset so it maps to RAM
	always_ff @(posedge clk)
	begin
		if (we)
			mem_r[waddr] <= wdata;
	end

	// Read register; old data on a same-address write
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_r <= `SBF_MEM_RD_RST;
		else
			rdata_r <= mem_r[raddr];
	end

	assign rdata = rdata_r;

endmodule

// file: tb/sbf_exec_chk.sv
`timescale 1ns/1ps

// Port-level checks for the execution unit
module sbf_exec_chk (
	input wire logic               pclk,        // Core clock
	input wire logic               presetn,     // Async reset, low active
	input wire logic               psel,        // APB select
	input wire logic               penable,     // APB access phase
	input wire logic               pwrite,      // APB direction
	input wire logic [11:0]        paddr,       // APB address
	input wire logic [31:0]        pwdata,      // APB write data
	input wire logic               pready,      // APB ready
	input wire sbf_pkg::sbf_byte_t status_reg,  // Status register
	input wire logic               irq_enable,  // Interrupt enable
	input wire logic               sleep_req,   // Sleep pulse
	input wire logic               wdt_restart  // Restart pulse
);
	import sbf_pkg::*;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Command accepted at this edge, and its opcode
	wire logic       cmd_go = psel && penable && pready && pwrite && (paddr == 12'h000);
	wire logic [4:0] cmd_op = pwdata[4:0];

	// Flags untouched while the command runs
	sequence s_kept;
		$stable(status_reg) [*3];
	endsequence
	// Exactly one cycle high
	sequence s_pulse(sig);
		sig ##1 !sig;
	endsequence
	// Forced flag lands two edges later, other bits kept
	property p_force(logic [4:0] op, logic [7:0] m, logic v);
		cmd_go && (cmd_op == op) |-> ##2
			(status_reg == (v ? ($past(status_reg, 2) | m) : ($past(status_reg, 2) & ~m)));
	endproperty

	a_io_clear_flags: assert property (cmd_go && (cmd_op == OP_IO_BIT_CLEAR) |=> s_kept)
		else $error("flags moved during io bit clear");
	a_swap_flags: assert property (cmd_go && (cmd_op == OP_NIBBLE_SWAP) |=> s_kept)
		else $error("flags moved during nibble swap");
	a_load_flags: assert property (cmd_go && (cmd_op == OP_TRANSFER_FLAG_LOAD) |=> s_kept)
		else $error("flags moved during bit load");
	a_sleep_pulse: assert property (
		cmd_go && (cmd_op == OP_SLEEP) |-> ##2 s_pulse(sleep_req))
		else $error("sleep request pulse wrong");
	a_restart_pulse: assert property (
		cmd_go && (cmd_op == OP_WATCHDOG_RESTART) |-> ##2 s_pulse(wdt_restart))
		else $error("watchdog restart pulse wrong");
	a_signed_set: assert property (p_force(OP_SET_SIGNED_FLAG, 8'h10, 1'b1))
		else $error("signed flag set wrong");
	a_signed_clear: assert property (p_force(OP_CLEAR_SIGNED_FLAG, 8'h10, 1'b0))
		else $error("signed flag clear wrong");
	a_overflow_set: assert property (p_force(OP_SET_OVERFLOW, 8'h08, 1'b1))
		else $error("overflow flag set wrong");
	a_half_clear: assert property (p_force(OP_CLEAR_HALF_CARRY, 8'h20, 1'b0))
		else $error("half carry clear wrong");
	a_irq_mirror: assert property (
		cmd_go && (cmd_op == OP_IRQ_GLOBAL_ON) |-> ##2 (irq_enable && status_reg[7]))
		else $error("interrupt enable not raised by irq on");
endmodule

bind sbf_exec sbf_exec_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .status_reg, .irq_enable, .sleep_req, .wdt_restart);

// file: tb/testbench.sv
`timescale 1ns/1ps

module testbench;
	import sbf_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic        irq_enable, sleep_req, wdt_restart;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  v, e;
	logic [15:0] m;
	sbf_byte_t   status_reg;
	int          error_cnt, check_count, sleep_cnt, wdt_cnt, c0;
	int          ops[8] = '{2, 3, 4, 5, 6, 7, 10, 11};    // Operand-bearing ops
	logic [7:0]  vals[4] = '{8'h81, 8'h40, 8'h00, 8'h7e}; // Edge-case operands
	int          fb[8] = '{0, 2, 1, 7, 4, 3, 6, 5};       // Flag of each set/clear pair

	sbf_exec dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .status_reg, .irq_enable, .sleep_req, .wdt_restart);

	// 100 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Count one-cycle pulses
	always @(posedge pclk)
	begin
		if (sleep_req === 1'b1) sleep_cnt++;
		if (wdt_restart === 1'b1) wdt_cnt++;
	end

	task chk(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want)
		begin
			error_cnt++;
			$display("ERROR %0t seen %h want %h", $time, seen, want);
		end
	endtask
	// One APB transfer; an idle edge first keeps drives one per step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait as long as the slave needs; only the hang guard ends a hang
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Status read once busy has dropped
	task stat();
		do apb(1'b0, 12'h004, 0); while (rd[8] !== 1'b0);
		v = rd[7:0];
	endtask
	task exec(input int op, input int r, input int b, input int io);
		apb(1'b1, 12'h000, {14'h0, 5'(io), 3'(b), 5'(r), 5'(op)});
	endtask
	// Expected register and status after an operand op
	function automatic logic [15:0] model(input int op, input logic [7:0] x, input logic [7:0] s,
		input int b);
		logic [7:0] r;
		logic       c;
		r = x;
		c = s[0];
		case (op)
			2: {c, r} = {x, 1'b0};
			3: {r, c} = {1'b0, x};
			4: {c, r} = {x, s[0]};
			5: {r, c} = {s[0], x};
			6: {r, c} = {x[7], x};
			7: r = {x[3:0], x[7:4]};
			10: s[6] = x[b];
			11: r[b] = s[6];
			default: ;
		endcase
		if (op <= 6) s[3:0] = {c ^ r[7], r[7], r == 8'h00, c};
		return {r, s};
	endfunction

	task wrap_up();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Hang guard, far beyond the expected run
	initial
	begin
		#300000;
		error_cnt++;
		wrap_up();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		chk({status_reg, irq_enable, sleep_req, wdt_restart}, 0);
		// Unmapped places answer with an error
		apb(1'b0, 12'h008, 0);
		chk(er, 1);
		chk(rd, 0);
		apb(1'b1, 12'h101, 8'h55);
		chk(er, 1);
		// Shifts, rotates, swap, bit store and load
		foreach (ops[i])
			foreach (vals[j])
			begin
				e = j[0] ? 8'h71 : 8'hb0;
				apb(1'b1, 12'h004, e);
				apb(1'b1, 12'h100 + 12'(4 * (28 + j)), vals[j]);
				exec(ops[i], 28 + j, 7 * j, 0);
				m = model(ops[i], vals[j], e, (7 * j) % 8);
				apb(1'b0, 12'h100 + 12'(4 * (28 + j)), 0);
				chk(rd[7:0], m[15:8]);
				stat();
				chk(v, m[7:0]);
			end
		// Back-to-back commands wait on each other
		apb(1'b1, 12'h100, 8'h01);
		repeat (3) exec(2, 0, 0, 0);
		apb(1'b0, 12'h100, 0);
		chk(rd[7:0], 8'h08);
		// Named and indexed flag forces
		for (int k = 0; k < 8; k++)
		begin
			for (int s = 0; s < 2; s++)
			begin
				apb(1'b1, 12'h004, 8'h5a);
				exec(12 + 2 * k + s, 0, 0, 0);
				stat();
				e = s ? (8'h5a & ~(8'h01 << fb[k])) : (8'h5a | (8'h01 << fb[k]));
				chk(v, e);
				chk(irq_enable, e[7]);
				apb(1'b1, 12'h004, s ? 8'hff : 8'h00);
				exec(8 + s, 0, k, 0);
				stat();
				e = s ? ~(8'h01 << k) : (8'h01 << k);
				chk(v, e);
			end
		end
		// No-operation and unused codes change nothing
		foreach (fb[k])
		begin
			apb(1'b1, 12'h004, 8'h3c);
			exec(k < 3 ? 0 : 30 + k % 2, 0, 0, 0);
			stat();
			chk(v, 8'h3c);
		end
		// I/O bit clear at both bit ends, neighbour kept
		apb(1'b1, 12'h004, 8'ha5);
		apb(1'b1, 12'h27c, 8'hff);
		apb(1'b1, 12'h278, 8'hff);
		exec(1, 0, 7, 31);
		exec(1, 0, 0, 31);
		apb(1'b0, 12'h27c, 0);
		chk(rd[7:0], 8'h7e);
		apb(1'b0, 12'h278, 0);
		chk(rd[7:0], 8'hff);
		stat();
		chk(v, 8'ha5);
		// Command word reads back the last command issued
		apb(1'b0, 12'h000, 0);
		chk(rd, 32'h0003_e001);
		// Sleep and watchdog restart
		apb(1'b1, 12'h004, 8'h96);
		c0 = sleep_cnt;
		exec(28, 0, 0, 0);
		stat();
		chk(sleep_cnt, c0 + 1);
		c0 = wdt_cnt;
		exec(29, 0, 0, 0);
		stat();
		chk(wdt_cnt, c0 + 1);
		chk(v, 8'h96);
		wrap_up();
	end
endmodule
